// ---- pmc_cap_reg.sv ----
// Power management capability register, read over configuration cycles.
// Assumes the configuration core decodes the offset and gives cfg_sel_i,
// and that requests are held off until cfg_ack_o answers.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_cap_reg
    import pmc_pkg::*;
(
    input  wire logic          clk_i,                // Clock, 200 MHz
    input  wire logic          reset_i,              // Synchronous reset, high
    input  wire logic          eeprom_load_i,        // Eeprom word valid pulse
    input  pmc_pkg::pmc_eep_t  eeprom_config_word_i, // Eeprom configuration word
    input  wire logic          cfg_sel_i,            // Register selected
    input  wire logic          cfg_rd_i,             // Config read request
    input  wire logic          cfg_wr_i,             // Config write request
    input  wire logic [1:0]    cfg_byte_en_i,        // Byte enables
    input  pmc_pkg::pmc_word_t cfg_wdata_i,          // Write data, discarded
    output pmc_pkg::pmc_word_t cfg_rdata_o,          // Read data
    output logic               cfg_ack_o,            // Access answered
    output logic               cap_loaded_o          // Eeprom fields valid
);
    import pmc_pkg::*;

    pmc_eep_if eep ();

    pmc_state_t             state_q, state_d;
    pmc_word_t              rdata_q, rdata_d;
    pmc_word_t              cap_value;
    pmc_word_t              lane_data;
    logic [`PMC_WAKE_W-1:0] wake_field;
    logic                   req_valid;
    logic                   req_read;
    logic                   unused_wdata;

    ////////////////////////////////////////////////////////////////////////
    // Eeprom field holder
    pmc_eep_load u_load (
        .clk_i                (clk_i),
        .reset_i              (reset_i),
        .load_i               (eeprom_load_i),
        .eeprom_config_word_i (eeprom_config_word_i),
        .eep                  (eep)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wake-source field, one bit per power state
    always_comb begin
        wake_field                   = '0;
        wake_field[`PMC_WAKE_D0]     = `PMC_WAKE_D0_VAL;
        wake_field[`PMC_WAKE_D1]     = eep.wake_loaded[0];
        wake_field[`PMC_WAKE_D2]     = eep.wake_loaded[1];
        wake_field[`PMC_WAKE_D3HOT]  = `PMC_WAKE_D3HOT_VAL;
        wake_field[`PMC_WAKE_D3COLD] = eep.wake_loaded[2];
    end

    // Assemble the register image. The image is combinational, so a read
    // taken in the cycle after a load already returns the new fields.
    //   15    wake from D3cold, eeprom
    //   14    wake from D3hot, fixed one
    //   13    wake from D2, eeprom
    //   12    wake from D1, eeprom
    //   11    wake from D0, fixed one
    //   10    deep sleep support, eeprom
    //   9     light sleep support, eeprom
    //   8..3  reserved, zero
    //   2..0  version code
    always_comb begin
        cap_value = '0;
        cap_value[`PMC_VERSION_MSB:`PMC_VERSION_LSB] = `PMC_VERSION_VAL;
        cap_value[`PMC_LIGHT_BIT]  = eep.light_sleep_capable;
        cap_value[`PMC_DEEP_BIT]   = eep.deep_sleep_capable;
        cap_value[`PMC_WAKE_MSB:`PMC_WAKE_LSB] = wake_field;
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane masking, one slice per byte enable; a disabled lane reads
    // zero so a partial read never carries bytes the host did not ask for
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
        assign lane_data[lane*8 +: 8] = cfg_byte_en_i[lane] ? cap_value[lane*8 +: 8] : 8'h00;
    end

    // Request qualifiers. In the answer cycle the host still holds the
    // request just answered, so nothing new may start there.
    assign req_valid = cfg_sel_i && (cfg_rd_i || cfg_wr_i) && (state_q == PMC_IDLE);
    // Both strobes at once count as a read
    assign req_read  = req_valid && cfg_rd_i;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer: take a request in idle, answer one cycle later
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        case (state_q)
            PMC_IDLE: begin
                if (req_valid) begin
                    state_d = PMC_ANS;
                    // A write only earns a zero answer; no field changes
                    rdata_d = '0;
                    if (req_read) begin
                        rdata_d = lane_data;
                    end
                end
            end
            PMC_ANS: begin
                state_d = PMC_IDLE;
            end
            default: begin
                state_d = PMC_IDLE;
                rdata_d = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= PMC_IDLE;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
        end
    end

    // Write data has no destination in a read-only register
    assign unused_wdata = ^cfg_wdata_i;

    // Outputs
    assign cfg_ack_o    = (state_q == PMC_ANS);
    assign cfg_rdata_o  = rdata_q;
    assign cap_loaded_o = eep.loaded;

endmodule

// ---- pmc_checker.sv ----
// Checker for the capability register port and its read image.
// Assumes it is bound onto pmc_cap_reg and sees only its ports.
`timescale 1ns/1ps

module pmc_checker
    import pmc_pkg::*;
(
    input  wire logic          clk_i,                // Clock
    input  wire logic          reset_i,              // Reset
    input  wire logic          eeprom_load_i,        // Load pulse
    input  pmc_pkg::pmc_eep_t  eeprom_config_word_i, // Eeprom word
    input  wire logic          cfg_sel_i,            // Select
    input  wire logic          cfg_rd_i,             // Read
    input  wire logic          cfg_wr_i,             // Write
    input  wire logic [1:0]    cfg_byte_en_i,        // Byte enables
    input  pmc_pkg::pmc_word_t cfg_wdata_i,          // Write data
    input  pmc_pkg::pmc_word_t cfg_rdata_o,          // Read data
    input  wire logic          cfg_ack_o,            // Answer
    input  wire logic          cap_loaded_o          // Fields valid
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic       take;
    logic       full_rd;
    logic [4:0] ld_q;
    // Request taken at this edge
    assign take = cfg_sel_i && (cfg_rd_i || cfg_wr_i) && !cfg_ack_o;
    assign full_rd = take && cfg_rd_i && (cfg_byte_en_i == 2'h3);
    // Last loaded eeprom bits
    always_ff @(posedge clk_i) begin
        if (eeprom_load_i) begin
            ld_q <= eeprom_config_word_i[4:0];
        end
    end
    // Load followed at once by a full read
    sequence s_load_read;
        eeprom_load_i ##1 (!eeprom_load_i && full_rd);
    endsequence
    ack_pulse_a: assert property (take |=> cfg_ack_o ##1 !cfg_ack_o)
        else $error("answer not a one cycle pulse");
    version_const_a: assert property (full_rd |=> cfg_rdata_o[2:0] == 3'h2)
        else $error("version field wrong");
    rsvd_zero_a: assert property (cfg_ack_o |-> cfg_rdata_o[8:3] == 6'h0)
        else $error("reserved bits not zero");
    wake_fixed_a: assert property (full_rd |=> cfg_rdata_o[11] && cfg_rdata_o[14])
        else $error("fixed wake bits not set");
    sleep_load_a: assert property (s_load_read |=> cfg_rdata_o[10:9] == ld_q[1:0])
        else $error("sleep support bits not loaded");
    wake_load_a: assert property (s_load_read |=>
        {cfg_rdata_o[15], cfg_rdata_o[13:12]} == {ld_q[4], ld_q[3:2]})
        else $error("wake bits not loaded");
    write_zero_a: assert property (take && cfg_wr_i && !cfg_rd_i |=> cfg_rdata_o == 16'h0)
        else $error("write answer not zero");
    rdata_hold_a: assert property (!take |=> $stable(cfg_rdata_o))
        else $error("read data moved without request");
    loaded_flag_a: assert property (eeprom_load_i |=> cap_loaded_o)
        else $error("loaded flag not set");
endmodule

bind pmc_cap_reg pmc_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
    .eeprom_load_i(eeprom_load_i), .eeprom_config_word_i(eeprom_config_word_i),
    .cfg_sel_i(cfg_sel_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
    .cfg_byte_en_i(cfg_byte_en_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .cap_loaded_o(cap_loaded_o));

// ---- pmc_defines.svh ----
// Constants of the power management capability register: field positions,
// reset values, constant field contents and the eeprom word bit map.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Register width, field positions and fixed version code
`define PMC_REG_W            16
`define PMC_VERSION_LSB      0
`define PMC_VERSION_MSB      2
`define PMC_VERSION_VAL      3'h2
`define PMC_RSVD_LSB         3
`define PMC_RSVD_MSB         8
`define PMC_LIGHT_BIT        9
`define PMC_DEEP_BIT         10
`define PMC_WAKE_LSB         11
`define PMC_WAKE_MSB         15
`define PMC_WAKE_W           5

// Wake-source bit positions inside the wake field
`define PMC_WAKE_D0          0
`define PMC_WAKE_D1          1
`define PMC_WAKE_D2          2
`define PMC_WAKE_D3HOT       3
`define PMC_WAKE_D3COLD      4

// Wake sources that are fixed in hardware
`define PMC_WAKE_D0_VAL      1'h1
`define PMC_WAKE_D3HOT_VAL   1'h1

// Eeprom word bit positions of the loadable fields
`define PMC_EEP_W            16
`define PMC_EEP_LIGHT_BIT    0
`define PMC_EEP_DEEP_BIT     1
`define PMC_EEP_WAKE_D1_BIT  2
`define PMC_EEP_WAKE_D2_BIT  3
`define PMC_EEP_WAKE_D3C_BIT 4

// Reset values of the loadable fields, before the eeprom load
`define PMC_LIGHT_RST        1'h0
`define PMC_DEEP_RST         1'h0
`define PMC_WAKE_LD_RST      3'h0

`endif

// ---- pmc_eep_if.sv ----
// Carrier for the fields loaded from the eeprom word.
// Assumes one loader drives it and the register core reads it.
`timescale 1ns/1ps

interface pmc_eep_if;
    logic       light_sleep_capable;    // Light sleep supported
    logic       deep_sleep_capable;     // Deep sleep supported
    logic [2:0] wake_loaded;            // Wake from D1, D2, D3cold
    logic       loaded;                 // Auto initialization done

    modport loader (output light_sleep_capable, deep_sleep_capable, wake_loaded, loaded);
    modport core   (input  light_sleep_capable, deep_sleep_capable, wake_loaded, loaded);
endinterface

// ---- pmc_eep_load.sv ----
// Holds the capability fields captured from the eeprom word.
// Assumes load_i pulses while the word is valid during auto initialization.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_eep_load
    import pmc_pkg::*;
(
    input  wire logic         clk_i,                // Clock
    input  wire logic         reset_i,              // Synchronous reset, high
    input  wire logic         load_i,               // Eeprom word valid pulse
    input  pmc_pkg::pmc_eep_t eeprom_config_word_i, // Eeprom configuration word
    pmc_eep_if.loader         eep                   // Loaded fields
);
    import pmc_pkg::*;

    logic       light_q, light_d;
    logic       deep_q, deep_d;
    logic [2:0] wake_q, wake_d;
    logic       done_q, done_d;

    ////////////////////////////////////////////////////////////////////////
    // Next values: capture on the load pulse, else hold
    always_comb begin
        light_d = light_q;
        deep_d  = deep_q;
        wake_d  = wake_q;
        done_d  = done_q;
        if (load_i) begin
            light_d   = eeprom_config_word_i[`PMC_EEP_LIGHT_BIT];
            deep_d    = eeprom_config_word_i[`PMC_EEP_DEEP_BIT];
            wake_d[0] = eeprom_config_word_i[`PMC_EEP_WAKE_D1_BIT];
            wake_d[1] = eeprom_config_word_i[`PMC_EEP_WAKE_D2_BIT];
            wake_d[2] = eeprom_config_word_i[`PMC_EEP_WAKE_D3C_BIT];
            done_d    = 1'h1;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            light_q <= `PMC_LIGHT_RST;
            deep_q  <= `PMC_DEEP_RST;
            wake_q  <= `PMC_WAKE_LD_RST;
            done_q  <= 1'h0;
        end else begin
            light_q <= light_d;
            deep_q  <= deep_d;
            wake_q  <= wake_d;
            done_q  <= done_d;
        end
    end

    // Drive the carrier
    assign eep.light_sleep_capable = light_q;
    assign eep.deep_sleep_capable  = deep_q;
    assign eep.wake_loaded         = wake_q;
    assign eep.loaded              = done_q;

endmodule

// ---- pmc_host_model.sv ----
// Host bridge model issuing one configuration cycle at a time.
// Assumes each request is answered by ack_i within a few cycles.
`timescale 1ns/1ps

module pmc_host_model
    import pmc_pkg::*;
(
    input  wire logic          clk_i,   // Clock
    input  wire logic          ack_i,   // Answer
    input  pmc_pkg::pmc_word_t rdata_i, // Read data
    output logic               sel_o,   // Select
    output logic               rd_o,    // Read
    output logic               wr_o,    // Write
    output logic [1:0]         be_o,    // Byte enables
    output pmc_pkg::pmc_word_t wdata_o  // Write data
);
    // Idle bus at time zero
    initial begin
        sel_o = 1'h0;
        rd_o = 1'h0;
        wr_o = 1'h0;
        be_o = 2'h0;
        wdata_o = 16'hffff;
    end
    // Hold request until answered; lanes invert once released
    task automatic access(input logic r, input logic w, input logic [1:0] b,
                          output pmc_word_t d);
        int n;
        @(posedge clk_i);
        #1;
        sel_o = 1'h1;
        rd_o = r;
        wr_o = w;
        be_o = b;
        wdata_o = ~wdata_o;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'h1 && n < 8);
        d = (ack_i === 1'h1) ? rdata_i : 16'hxxxx;
        #1;
        sel_o = 1'h0;
        rd_o = 1'h0;
        wr_o = 1'h0;
        be_o = ~be_o;
        wdata_o = ~wdata_o;
    endtask
endmodule

// ---- pmc_pkg.sv ----
// Types shared by the power management capability block.
// Assumes pmc_defines.svh is on the include path.
`include "pmc_defines.svh"

package pmc_pkg;

    // Register-wide data word
    typedef logic [`PMC_REG_W-1:0] pmc_word_t;

    // Eeprom configuration word
    typedef logic [`PMC_EEP_W-1:0] pmc_eep_t;

    // Configuration access sequencer, Gray coded along idle -> answer
    typedef enum logic [1:0] {
        PMC_IDLE = 2'h0,
        PMC_ANS  = 2'h1
    } pmc_state_t;

endpackage

// ---- tb_top.sv ----
// Self-checking bench for the capability register.
// Assumes the checker binds itself and the host model drives cycles.
`timescale 1ns/1ps

module tb_top;
    import pmc_pkg::*;
    logic       clk_i = 1'h0;
    logic       reset_i = 1'h1;
    logic       load = 1'h0;
    pmc_eep_t   word = 16'h0;
    logic       sel, rd, wr, ack, ldd;
    logic [1:0] be;
    pmc_word_t  wdata, rdata, d;
    int         mismatches = 0;
    int         num_checks = 0;
    int         cyc = 0;
    // Clock, 5 ns period
    always #2.5 clk_i = ~clk_i;
    pmc_cap_reg dut (.clk_i(clk_i), .reset_i(reset_i), .eeprom_load_i(load),
        .eeprom_config_word_i(word), .cfg_sel_i(sel), .cfg_rd_i(rd), .cfg_wr_i(wr),
        .cfg_byte_en_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .cap_loaded_o(ldd));
    pmc_host_model host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .sel_o(sel),
        .rd_o(rd), .wr_o(wr), .be_o(be), .wdata_o(wdata));
    // Expected image for an eeprom word
    function automatic pmc_word_t img(pmc_eep_t w);
        return {w[4], 1'b1, w[3], w[2], 1'b1, w[1], w[0], 6'h0, 3'h2};
    endfunction
    task automatic chk_w(pmc_word_t e, pmc_word_t g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_b(logic e, logic g);
        chk_w({15'h0, e}, {15'h0, g});
    endtask
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd_chk(logic [1:0] b, pmc_word_t e);
        host.access(1'h1, 1'h0, b, d);
        chk_w(e, d);
    endtask
    task automatic ld(pmc_eep_t w);
        @(posedge clk_i);
        #1;
        load = 1'h1;
        word = w;
        @(posedge clk_i);
        #1;
        load = 1'h0;
    endtask
    task automatic t_reset;
        rd_chk(2'h3, 16'h4802);
        chk_b(1'h0, ldd);
    endtask
    task automatic t_each_bit;
        for (int i = 0; i < 5; i++) begin
            ld(16'h1 << i);
            rd_chk(2'h3, img(16'h1 << i));
        end
        chk_b(1'h1, ldd);
    endtask
    task automatic t_last_wins;
        @(posedge clk_i);
        #1;
        load = 1'h1;
        word = 16'h001f;
        @(posedge clk_i);
        #1;
        word = 16'h0012;
        fork
            begin
                @(posedge clk_i);
                #1;
                load = 1'h0;
            end
            host.access(1'h1, 1'h0, 2'h3, d);
        join
        chk_w(img(16'h0012), d);
    endtask
    task automatic t_write;
        host.access(1'h0, 1'h1, 2'h3, d);
        chk_w(16'h0, d);
        rd_chk(2'h3, img(16'h0012));
        host.access(1'h1, 1'h1, 2'h3, d);
        chk_w(img(16'h0012), d);
        rd_chk(2'h1, img(16'h0012) & 16'h00ff);
        rd_chk(2'h2, img(16'h0012) & 16'hff00);
        rd_chk(2'h0, 16'h0000);
    endtask
    task automatic t_mid_reset;
        @(posedge clk_i);
        #1;
        reset_i = 1'h1;
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'h0;
        chk_b(1'h0, ldd);
        rd_chk(2'h3, 16'h4802);
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        reset_i = 1'h0;
        t_reset();
        t_each_bit();
        t_last_wins();
        t_write();
        t_mid_reset();
        end_sim();
    end
endmodule
